// ### inc/tpi_defines.vh
// Constants of the timer, PWM and IR carrier block: register byte
// addresses, field positions and reset values.
// Assumes inclusion by bare name from the design file.
`ifndef TPI_DEFINES_VH
`define TPI_DEFINES_VH
// Register byte addresses on the 8-bit APB address
`define TPI_A_CTRL 8'h00
`define TPI_A_PRESC 8'h04
`define TPI_A_PER16 8'h08
`define TPI_A_CNT16 8'h0C
`define TPI_A_CHMODE 8'h10
`define TPI_A_CH0 8'h14
`define TPI_A_T8A 8'h28
`define TPI_A_CNT8 8'h30
`define TPI_A_STAT 8'h34
`define TPI_A_IEN 8'h38
`define TPI_A_ICLR 8'h3C
// Control bits
`define TPI_CTRL_RUN16 0
`define TPI_CTRL_IR 1
`define TPI_CTRL_RUN8A 2
`define TPI_CTRL_W 4
// Event bits: 16-bit wrap, five channels, then two 8-bit wraps
`define TPI_EV_WRAP16 0
`define TPI_EV_CH0 1
`define TPI_EV_WRAP8A 6
`define TPI_EV_W 8
// Reset values
`define TPI_RST_PER16 16'hFFFF
`define TPI_RST_PER8 8'hFF
`define TPI_RST_ZERO 32'h00000000
`endif

// ### verilog/tpi_timer_pwm_ir.v
// Timer block: one 16-bit timer with five compare/capture channels,
// two 8-bit timers with one PWM channel each, and an IR carrier mode.
// Assumes a single 10 MHz clock, synchronous reset and an APB master;
// capture pins are asynchronous and are synchronised here.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tpi_defines.vh"

module tpi_timer_pwm_ir (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [4:0] i_cap,
  output wire [4:0] o_pwm16,
  output wire [1:0] o_pwm8,
  output wire o_ir,
  output wire o_irq,
  output wire o_dma_req
);

  reg [`TPI_CTRL_W-1:0] ctrl_ff;
  reg [23:0] presc_ff;
  reg [15:0] per16_ff;
  reg [15:0] pre16_ff;
  reg [15:0] cnt16_ff;
  reg [4:0] chmode_ff;
  reg [`TPI_EV_W-1:0] stat_ff;
  reg [`TPI_EV_W-1:0] ien_ff;
  reg [31:0] prdata_ff;
  reg ir_ff;
  reg dma_ff;
  reg [31:0] nxt_rdata;
  reg hit;
  wire [1:0] wrap8;
  wire [1:0] pwm8;
  wire [15:0] cnt8;
  wire [31:0] cfg8;
  wire [4:0] pwm16;
  wire [4:0] ev_ch;
  wire [79:0] chval;
  wire wr;
  wire ir_mode;
  wire run16;
  wire ptick16;
  wire adv16;
  wire wrap16;
  wire [`TPI_EV_W-1:0] ev;
  wire [`TPI_EV_W-1:0] clr;

  // Zero-wait slave: read data is latched in setup, so pready can sit high
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_prdata = prdata_ff;
  assign wr = i_psel & i_penable & i_pwrite & hit;

  assign ir_mode = ctrl_ff[`TPI_CTRL_IR];
  assign run16 = ctrl_ff[`TPI_CTRL_RUN16];

  // prescaler tick for the 16-bit counter
  assign ptick16 = run16 && (pre16_ff == {8'h00, presc_ff[7:0]});
  // IR mode counts first 8-bit periods
  assign adv16 = run16 && (ir_mode ? wrap8[0] : ptick16);
  assign wrap16 = adv16 && (cnt16_ff == per16_ff);

  // each register decodes to one word, any master may use it
  always @* begin
    nxt_rdata = `TPI_RST_ZERO;
    hit = 1'b1;
    case (i_paddr)
      `TPI_A_CTRL: nxt_rdata[`TPI_CTRL_W-1:0] = ctrl_ff;
      `TPI_A_PRESC: nxt_rdata[23:0] = presc_ff;
      `TPI_A_PER16: nxt_rdata[15:0] = per16_ff;
      `TPI_A_CNT16: nxt_rdata[15:0] = cnt16_ff;
      `TPI_A_CHMODE: nxt_rdata[4:0] = chmode_ff;
      `TPI_A_CH0: nxt_rdata[15:0] = chval[15:0];
      `TPI_A_CH0 + 8'h04: nxt_rdata[15:0] = chval[31:16];
      `TPI_A_CH0 + 8'h08: nxt_rdata[15:0] = chval[47:32];
      `TPI_A_CH0 + 8'h0C: nxt_rdata[15:0] = chval[63:48];
      `TPI_A_CH0 + 8'h10: nxt_rdata[15:0] = chval[79:64];
      `TPI_A_T8A: nxt_rdata[15:0] = cfg8[15:0];
      `TPI_A_T8A + 8'h04: nxt_rdata[15:0] = cfg8[31:16];
      `TPI_A_CNT8: nxt_rdata[15:0] = cnt8;
      `TPI_A_STAT: nxt_rdata[`TPI_EV_W-1:0] = stat_ff;
      `TPI_A_IEN: nxt_rdata[`TPI_EV_W-1:0] = ien_ff;
      `TPI_A_ICLR: nxt_rdata = `TPI_RST_ZERO;
      default: hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle; address is stable until done
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      prdata_ff <= `TPI_RST_ZERO;
    end else if (i_psel & ~i_penable) begin
      prdata_ff <= nxt_rdata;
    end
  end

  // Configuration registers written by software
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_ff <= {`TPI_CTRL_W{1'b0}};
      presc_ff <= 24'h000000;
      per16_ff <= `TPI_RST_PER16;
      chmode_ff <= 5'h00;
      ien_ff <= {`TPI_EV_W{1'b0}};
    end else if (wr) begin
      if (i_paddr == `TPI_A_CTRL) ctrl_ff <= i_pwdata[`TPI_CTRL_W-1:0];
      if (i_paddr == `TPI_A_PRESC) presc_ff <= i_pwdata[23:0];
      if (i_paddr == `TPI_A_PER16) per16_ff <= i_pwdata[15:0];
      if (i_paddr == `TPI_A_CHMODE) chmode_ff <= i_pwdata[4:0];
      if (i_paddr == `TPI_A_IEN) ien_ff <= i_pwdata[`TPI_EV_W-1:0];
    end
  end

  // 16-bit counter restarts at zero after its period
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      pre16_ff <= 16'h0000;
      cnt16_ff <= 16'h0000;
    end else begin
      if (!run16 || ptick16) begin
        pre16_ff <= 16'h0000;
      end else begin
        pre16_ff <= pre16_ff + 16'h0001;
      end
      if (wrap16) begin
        cnt16_ff <= 16'h0000;
      end else if (adv16) begin
        cnt16_ff <= cnt16_ff + 16'h0001;
      end
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  assign clr = (wr && i_paddr == `TPI_A_ICLR) ?
               i_pwdata[`TPI_EV_W-1:0] : {`TPI_EV_W{1'b0}};
  assign ev = {wrap8, ev_ch, wrap16};
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      stat_ff <= {`TPI_EV_W{1'b0}};
    end else begin
      stat_ff <= (stat_ff & ~clr) | ev;
    end
  end
  assign o_irq = |(stat_ff & ien_ff);

  // DMA request pulses once per 16-bit period
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      dma_ff <= 1'b0;
    end else begin
      dma_ff <= wrap16;
    end
  end
  assign o_dma_req = dma_ff;

  // Five compare/capture channels of the 16-bit timer
  genvar j;
  generate
    for (j = 0; j < 5; j = j + 1) begin : g_ch
      localparam integer OFS = 4 * j;
      localparam [7:0] LA = `TPI_A_CH0 + OFS[7:0];
      reg [15:0] val_ff;
      reg pwm_ff;
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg flt_ff;
      reg ev_ff;
      wire cap_mode;
      wire rise;
      wire match;
      assign cap_mode = chmode_ff[j];
      // stable when second and third stages agree
      assign rise = (s2_ff == s3_ff) && s2_ff && !flt_ff;
      assign match = !cap_mode && adv16 && (cnt16_ff == val_ff);
      // three-stage synchroniser on the capture pin
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          flt_ff <= 1'b0;
        end else begin
          s1_ff <= i_cap[j];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) flt_ff <= s2_ff;
        end
      end
      // capture wins over a software write in the same cycle
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          val_ff <= 16'h0000;
          ev_ff <= 1'b0;
        end else begin
          ev_ff <= (cap_mode && rise) || match;
          if (cap_mode && rise) begin
            val_ff <= cnt16_ff;
          end else if (wr && i_paddr == LA) begin
            val_ff <= i_pwdata[15:0];
          end
        end
      end
      // high from period start, low at compare match
      always @(posedge i_clock) begin
        if (i_sys_rst || cap_mode) begin
          pwm_ff <= 1'b0;
        end else if (wrap16) begin
          pwm_ff <= 1'b1;
        end else if (match) begin
          pwm_ff <= 1'b0;
        end
      end
      assign chval[16*j +: 16] = val_ff;
      assign pwm16[j] = pwm_ff;
      assign ev_ch[j] = ev_ff;
    end
  endgenerate
  assign o_pwm16 = pwm16;

  // Two 8-bit timers, each with period and compare in one register
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_t8
      localparam integer OFS = 4 * k;
      localparam [7:0] LA = `TPI_A_T8A + OFS[7:0];
      reg [7:0] pre_ff;
      reg [7:0] cnt_ff;
      reg [15:0] cfg_ff;
      reg pwm_ff;
      wire run;
      wire tick;
      wire wrap;
      // first timer forced on as carrier in IR mode
      assign run = ctrl_ff[`TPI_CTRL_RUN8A + k] | ((k == 0) & ir_mode);
      assign tick = run && (pre_ff == presc_ff[8 * k + 8 +: 8]);
      assign wrap = tick && (cnt_ff == cfg_ff[7:0]);
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          cfg_ff <= {8'h00, `TPI_RST_PER8};
        end else if (wr && i_paddr == LA) begin
          cfg_ff <= i_pwdata[15:0];
        end
      end
      // counter restarts after reaching the period
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          pre_ff <= 8'h00;
          cnt_ff <= 8'h00;
        end else begin
          if (!run || tick) begin
            pre_ff <= 8'h00;
          end else begin
            pre_ff <= pre_ff + 8'h01;
          end
          if (wrap) begin
            cnt_ff <= 8'h00;
          end else if (tick) begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
      end
      // PWM from period start to compare match
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          pwm_ff <= 1'b0;
        end else if (wrap) begin
          pwm_ff <= 1'b1;
        end else if (tick && cnt_ff == cfg_ff[15:8]) begin
          pwm_ff <= 1'b0;
        end
      end
      assign wrap8[k] = wrap;
      assign pwm8[k] = pwm_ff;
      assign cnt8[8 * k +: 8] = cnt_ff;
      assign cfg8[16 * k +: 16] = cfg_ff;
    end
  endgenerate
  assign o_pwm8 = pwm8;

  // envelope from channel 0 gates the carrier
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ir_ff <= 1'b0;
    end else begin
      ir_ff <= ir_mode & pwm16[0] & pwm8[0];
    end
  end
  assign o_ir = ir_ff;

endmodule

// ### sim/tpi_checker.sv
// Checker of the timer block's bus and pin ports.
// Assumes one clock domain with a synchronous high reset.
`timescale 1ns/1ps
module tpi_checker (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire [7:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [4:0] o_pwm16,
  input wire [1:0] o_pwm8,
  input wire o_ir,
  input wire o_irq,
  input wire o_dma_req
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  // Access phase of a transfer
  wire acc;
  assign acc = i_psel && i_penable;
  a_zero_wait: assert property (o_pready)
    else $error("pready low");
  a_bad_addr: assert property (acc && i_paddr > 8'h3C |-> o_pslverr)
    else $error("no error on unmapped address");
  a_good_addr: assert property (acc && i_paddr <= 8'h3C &&
    i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("error on mapped address");
  a_idle_err: assert property (!acc |-> !o_pslverr)
    else $error("error outside access");
  // Read data may only move at a setup edge
  a_rdata_hold: assert property ((!i_psel || i_penable) |=>
    $stable(o_prdata))
    else $error("read data moved");
  a_ir_gate: assert property (o_ir |->
    $past(o_pwm16[0]) && $past(o_pwm8[0]))
    else $error("ir high without both sources");
  a_dma_pulse: assert property (o_dma_req |=> !o_dma_req)
    else $error("dma request too long");
  a_rst_quiet: assert property ($fell(i_sys_rst) |-> o_pwm16 == 5'h00 &&
    o_pwm8 == 2'h0 && !o_ir && !o_irq && !o_dma_req)
    else $error("outputs active after reset");
endmodule

bind tpi_timer_pwm_ir tpi_checker tpi_checker_inst (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_pwm16(o_pwm16), .o_pwm8(o_pwm8),
  .o_ir(o_ir), .o_irq(o_irq), .o_dma_req(o_dma_req));

// ### sim/tpi_pin_model.sv
// Model of the signal sources on the capture pins.
// Assumes the bench calls pulse from its own process.
`timescale 1ns/1ps
module tpi_pin_model (
  input wire i_clock,
  output logic [4:0] o_cap
);
  initial o_cap = 5'h00;
  // pulse held whole clocks
  // Short pulses would slip past the synchronisers, so len is >= 2
  task automatic pulse(input int ch, input int len);
    @(posedge i_clock);
    o_cap[ch] <= 1'b1;
    repeat (len) @(posedge i_clock);
    o_cap[ch] <= 1'b0;
  endtask
endmodule

// ### sim/tpi_timer_pwm_ir_tb.sv
// Self-checking bench of the timer block over APB and its pins.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps
module tpi_timer_pwm_ir_tb;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata;
  logic rerr;
  wire [31:0] prdata;
  wire pready, pslverr, ir, irq, dma;
  wire [4:0] cap, pwm16;
  wire [1:0] pwm8;
  wire [4:0] mon = {pwm8[1], ir, dma, pwm16[0], pwm8[0]};
  int fail_count = 0;
  int checks = 0;
  tpi_timer_pwm_ir tpi_timer_pwm_ir_inst (.i_clock(clk), .i_sys_rst(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cap(cap), .o_pwm16(pwm16), .o_pwm8(pwm8),
    .o_ir(ir), .o_irq(irq), .o_dma_req(dma));
  tpi_pin_model tpi_pin_model_inst (.i_clock(clk), .o_cap(cap));
  // Free running 10 MHz clock
  initial forever #50 clk = ~clk;
  task automatic print_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 9; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 9) begin
      fail_count++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Cycles between two rising edges of one monitored pin
  task automatic gap(input int s, output int p);
    int r;
    logic last;
    r = 0;
    p = 0;
    last = 1'b1;
    for (int n = 0; n < 900 && r < 2; n++) begin
      @(negedge clk);
      p += r;
      if (mon[s] === 1'b1 && !last) r++;
      last = mon[s] === 1'b1;
    end
    if (r < 2) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic t_reset;
    xfer(0, 8'h08, 32'h0);
    `CHK(rdata, 32'h0000FFFF)
    xfer(0, 8'h2C, 32'h0);
    `CHK(rdata, 32'h000000FF)
    xfer(1, 8'h0C, 32'h1234);
    xfer(0, 8'h0C, 32'h0);
    `CHK(rdata, 32'h0)
    xfer(0, 8'h40, 32'h0);
    `CHK({rerr, rdata}, 33'h100000000)
    $display("t_reset done");
  endtask
  task automatic t_pwm8;
    int p;
    xfer(1, 8'h28, 32'h0103);
    xfer(1, 8'h2C, 32'h0102);
    xfer(1, 8'h04, 32'h0100);
    xfer(1, 8'h00, 32'hC);
    gap(0, p);
    `CHK(p, 8)
    gap(4, p);
    `CHK(p, 3)
    xfer(1, 8'h00, 32'h0);
    $display("t_pwm8 done");
  endtask
  task automatic t_pwm16;
    int p;
    int h4;
    int h2;
    h4 = 0;
    h2 = 0;
    xfer(1, 8'h08, 32'h4);
    xfer(1, 8'h04, 32'h1);
    xfer(1, 8'h14, 32'h2);
    xfer(1, 8'h24, 32'h3);
    xfer(1, 8'h38, 32'h1);
    xfer(1, 8'h00, 32'h1);
    gap(1, p);
    `CHK(p, 10)
    gap(2, p);
    `CHK(p, 10)
    `CHK(irq, 1'b1)
    // Duty over one period: channel 4 compares at 3, channels 2 and 3 at 0
    repeat (10) begin
      @(negedge clk);
      h4 += pwm16[4];
      h2 += pwm16[2] + pwm16[3];
    end
    `CHK(h4, 8)
    `CHK(h2, 4)
    xfer(0, 8'h34, 32'h0);
    `CHK(rdata[1:0], 2'h3)
    xfer(1, 8'h38, 32'h0);
    @(negedge clk);
    `CHK(irq, 1'b0)
    xfer(1, 8'h00, 32'h0);
    xfer(1, 8'h3C, 32'hFF);
    xfer(1, 8'h38, 32'h1);
    xfer(0, 8'h34, 32'h0);
    `CHK({irq, rdata}, 33'h0)
    $display("t_pwm16 done");
  endtask
  task automatic t_capture;
    logic [31:0] c0;
    xfer(1, 8'h08, 32'hFFFF);
    xfer(1, 8'h04, 32'h0);
    xfer(1, 8'h10, 32'h2);
    xfer(1, 8'h00, 32'h1);
    xfer(0, 8'h0C, 32'h0);
    c0 = rdata;
    tpi_pin_model_inst.pulse(1, 2);
    repeat (6) @(posedge clk);
    xfer(0, 8'h18, 32'h0);
    `CHK(rdata > c0 && rdata < c0 + 32'd30, 1'b1)
    `CHK(pwm16[1], 1'b0)
    xfer(0, 8'h34, 32'h0);
    `CHK(rdata[2], 1'b1)
    $display("t_capture done");
  endtask
  task automatic t_ir;
    int p;
    int hi;
    logic seen;
    seen = 1'b0;
    hi = 0;
    // Mid-run reset: the count left by capture sits above any small
    // period and would need a full 16-bit roll before it wraps
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1, 8'h10, 32'h0);
    xfer(1, 8'h28, 32'h1);
    xfer(1, 8'h08, 32'h2);
    xfer(1, 8'h14, 32'h1);
    xfer(1, 8'h00, 32'h3);
    gap(2, p);
    `CHK(p, 6)
    repeat (12) begin
      @(negedge clk);
      seen = seen | (ir === 1'b1);
      hi += ir;
    end
    `CHK(seen, 1'b1)
    // Two carrier highs inside each four-cycle envelope, two periods
    `CHK(hi, 4)
    $display("t_ir done");
  endtask
  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pwm8();
    t_pwm16();
    t_capture();
    t_ir();
    print_verdict();
  end
endmodule
